// File: rtl/krat_map.vh
`ifndef KRAT_MAP_VH
`define KRAT_MAP_VH

// Register byte offsets
`define KRAT_CTRL_OFS       5'h00
`define KRAT_STAT_OFS       5'h04
`define KRAT_IRQ_STAT_OFS   5'h08
`define KRAT_IRQ_MASK_OFS   5'h0c

// Control register fields
`define KRAT_CTRL_TRAIN_REQ 0
`define KRAT_CTRL_AN_DIS    1
`define KRAT_CTRL_ADV_KR    2
`define KRAT_CTRL_FEC_EN    3
`define KRAT_CTRL_SW_EN     4
`define KRAT_CTRL_RESTART   5
`define KRAT_CTRL_RESET     6'h10

// Status register fields
`define KRAT_STAT_TRAIN_EN  0
`define KRAT_STAT_LINK_UP   1
`define KRAT_STAT_LP_FEC    2
`define KRAT_STAT_RUNNING   3
`define KRAT_STAT_DONE      4
`define KRAT_STAT_TIMEOUT   5

// Interrupt status and mask fields
`define KRAT_IRQ_LINK_UP    0
`define KRAT_IRQ_TIMEOUT    1
`define KRAT_IRQ_LP_FEC     2
`define KRAT_IRQ_DONE       3
`define KRAT_IRQ_W          4
`define KRAT_IRQ_MASK_RESET 4'h0

// Training time limit
`define KRAT_CLK_MHZ        100
`define KRAT_TRAIN_LIMIT_MS 500
`define KRAT_TRAIN_LIMIT_CYC (`KRAT_TRAIN_LIMIT_MS * 1000 * `KRAT_CLK_MHZ)

`endif

// File: rtl/krat_sync.v
`timescale 1ns/1ps
`default_nettype none

// Three-flop input synchroniser; output moves once flops two and three agree
module krat_sync #(
	parameter W = 4
) (
	// Clock and reset
	input  wire         clk,
	input  wire         rst,
	// Asynchronous in, filtered out
	input  wire [W-1:0] din,
	output wire [W-1:0] dout
);

	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	reg [W-1:0] s3_reg;
	reg [W-1:0] out_reg;
	integer     i;

	// Shift chain and agreement filter
	always @(posedge clk)
	begin
		if (rst)
		begin
			s1_reg  <= {W{1'b0}};
			s2_reg  <= {W{1'b0}};
			s3_reg  <= {W{1'b0}};
			out_reg <= {W{1'b0}};
		end
		else
		begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (i = 0; i < W; i = i + 1)
				if (s2_reg[i] == s3_reg[i])
					out_reg[i] <= s3_reg[i];
		end
	end

	assign dout = out_reg;

endmodule
`default_nettype wire

// File: rtl/krat_ctrl.v
// Notes on behaviour
// - AN absent or AN link-up: training enabled and restarted if requested.
// - Any AN restart holds training disabled until AN link-up returns.
// - With the training request bit clear, training never runs.
// - AN absent or disabled: training still runs, sequenced by configuration bits.
// - Partner FEC request never enables local FEC; only software does.
// - Partner FEC request is reported in a status bit and on a pin.
// - Training must finish within 500 ms, else AN cannot complete.
// - The training restart control bit clears itself after being set.
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "krat_map.vh"

module krat_ctrl #(
	parameter [31:0] TRAIN_LIMIT_CYC = `KRAT_TRAIN_LIMIT_CYC
) (
	// Clock and reset
	input  wire        CLK_SYS,
	input  wire        SYS_RST,
	// Avalon-MM slave
	input  wire [4:0]  AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [3:0]  AVS_BYTEENABLE,
	input  wire [31:0] AVS_WRITEDATA,
	output reg  [31:0] AVS_READDATA,
	output wire        AVS_WAITREQUEST,
	// Auto-negotiation and training status in
	input  wire        AN_PRESENT,
	input  wire        AN_LINK_UP,
	input  wire        AN_RESTART,
	input  wire        LP_FEC_REQ,
	input  wire        TRAIN_DONE,
	// Training and configuration out
	output reg         TRAIN_EN,
	output reg         TRAIN_RESTART,
	output reg         FEC_EN,
	output reg         ADV_KR,
	output reg         AN_ENABLE,
	output reg         LP_FEC_REQ_STAT,
	// Interrupt
	output reg         IRQ
);

	reg  [5:0]  ctrl_reg;
	reg  [3:0]  irq_stat_reg;
	reg  [3:0]  irq_mask_reg;
	reg  [3:0]  irq_set;
	reg         rd_ack_reg;
	reg         train_en_reg;
	reg         timeout_reg;
	reg  [31:0] timer_reg;
	reg         link_d_reg;
	reg         restart_d_reg;
	reg         fec_d_reg;
	reg         done_d_reg;
	reg         treq_d_reg;
	reg         an_used_d_reg;
	wire [3:0]  sync_out;
	wire        link_up;
	wire        an_rst;
	wire        lp_fec;
	wire        tr_done;
	wire        an_used;
	wire        treq;
	wire        sw_en;
	wire        link_rise;
	wire        an_abort;
	wire        auto_start;
	wire        sw_restart;
	wire        restart_now;
	wire        wr_ctrl;
	wire        rd_take;

	// Register select on the bus address
	function reg_hit;
		input [4:0] addr;
		input [4:0] ofs;
		begin
			reg_hit = (addr == ofs);
		end
	endfunction

	// Pin inputs through the synchroniser
	krat_sync #(
		.W (4)
	) u_sync (
		.clk  (CLK_SYS),
		.rst  (SYS_RST),
		.din  ({TRAIN_DONE, LP_FEC_REQ, AN_RESTART, AN_LINK_UP}),
		.dout (sync_out)
	);

	assign link_up = sync_out[0];
	assign an_rst  = sync_out[1];
	assign lp_fec  = sync_out[2];
	assign tr_done = sync_out[3];

	// Sequencing terms
	assign an_used     = AN_PRESENT & ~ctrl_reg[`KRAT_CTRL_AN_DIS];
	assign treq        = ctrl_reg[`KRAT_CTRL_TRAIN_REQ];
	assign sw_en       = ctrl_reg[`KRAT_CTRL_SW_EN];
	assign link_rise   = link_up & ~link_d_reg;
	assign an_abort    = an_used & ((an_rst & ~restart_d_reg) | (~link_up & link_d_reg));
	assign auto_start  = an_used ? link_rise : ((treq & ~treq_d_reg) | (~an_used & an_used_d_reg));
	assign sw_restart  = ctrl_reg[`KRAT_CTRL_RESTART];
	assign restart_now = treq & sw_en & (auto_start | sw_restart) & ~an_abort
		& (~an_used | link_up);
	assign wr_ctrl     = AVS_WRITE & AVS_BYTEENABLE[0] & reg_hit(AVS_ADDRESS, `KRAT_CTRL_OFS);
	assign rd_take     = AVS_READ & rd_ack_reg;

	// Reads wait one cycle for registered data, writes never wait
	assign AVS_WAITREQUEST = AVS_READ & ~rd_ack_reg;

	// Interrupt events
	always @*
	begin
		irq_set = 4'h0;
		irq_set[`KRAT_IRQ_LINK_UP] = link_rise;
		irq_set[`KRAT_IRQ_TIMEOUT] = train_en_reg & ~tr_done & ~timeout_reg
			& (timer_reg == TRAIN_LIMIT_CYC - 1);
		irq_set[`KRAT_IRQ_LP_FEC]  = lp_fec & ~fec_d_reg;
		irq_set[`KRAT_IRQ_DONE]    = tr_done & ~done_d_reg;
	end

	// Bus registers and interrupt status
	always @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			ctrl_reg     <= `KRAT_CTRL_RESET;
			irq_mask_reg <= `KRAT_IRQ_MASK_RESET;
			irq_stat_reg <= 4'h0;
			rd_ack_reg   <= 1'b0;
			AVS_READDATA <= 32'h0;
		end
		else
		begin
			rd_ack_reg <= AVS_READ & ~rd_ack_reg;
			ctrl_reg[`KRAT_CTRL_RESTART] <= 1'b0;
			if (wr_ctrl)
				ctrl_reg <= AVS_WRITEDATA[5:0];
			if (AVS_WRITE & AVS_BYTEENABLE[0] & reg_hit(AVS_ADDRESS, `KRAT_IRQ_MASK_OFS))
				irq_mask_reg <= AVS_WRITEDATA[3:0];
			// Clear on read only what was returned, a new event wins
			if (rd_take & reg_hit(AVS_ADDRESS, `KRAT_IRQ_STAT_OFS))
				irq_stat_reg <= (irq_stat_reg & ~AVS_READDATA[3:0]) | irq_set;
			else
				irq_stat_reg <= irq_stat_reg | irq_set;
			if (AVS_READ & ~rd_ack_reg)
			begin
				case (AVS_ADDRESS)
					`KRAT_CTRL_OFS:     AVS_READDATA <= {26'h0, ctrl_reg};
					`KRAT_STAT_OFS:     AVS_READDATA <= {26'h0, timeout_reg,
								tr_done, train_en_reg & ~tr_done,
								lp_fec, link_up, train_en_reg};
					`KRAT_IRQ_STAT_OFS: AVS_READDATA <= {28'h0, irq_stat_reg};
					`KRAT_IRQ_MASK_OFS: AVS_READDATA <= {28'h0, irq_mask_reg};
					default:            AVS_READDATA <= 32'h0;
				endcase
			end
		end
	end

	// Training enable, restart and time limit
	always @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			train_en_reg  <= 1'b0;
			timeout_reg   <= 1'b0;
			timer_reg     <= 32'h0;
			TRAIN_RESTART <= 1'b0;
			link_d_reg    <= 1'b0;
			restart_d_reg <= 1'b0;
			fec_d_reg     <= 1'b0;
			done_d_reg    <= 1'b0;
			treq_d_reg    <= 1'b0;
			an_used_d_reg <= 1'b0;
		end
		else
		begin
			link_d_reg    <= link_up;
			restart_d_reg <= an_rst;
			fec_d_reg     <= lp_fec;
			done_d_reg    <= tr_done;
			treq_d_reg    <= treq;
			an_used_d_reg <= an_used;
			TRAIN_RESTART <= restart_now;
			if (~treq | ~sw_en)
				train_en_reg <= 1'b0;
			else if (an_abort)
				train_en_reg <= 1'b0;
			else if (restart_now)
				train_en_reg <= 1'b1;
			else if (an_used & ~link_up)
				train_en_reg <= 1'b0;
			// Time limit on one training attempt
			if (restart_now | ~train_en_reg | tr_done)
				timer_reg <= 32'h0;
			else if (timer_reg != TRAIN_LIMIT_CYC - 1)
				timer_reg <= timer_reg + 32'h1;
			if (restart_now)
				timeout_reg <= 1'b0;
			else if (irq_set[`KRAT_IRQ_TIMEOUT])
				timeout_reg <= 1'b1;
		end
	end

	// Registered outputs
	always @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			TRAIN_EN        <= 1'b0;
			FEC_EN          <= 1'b0;
			ADV_KR          <= 1'b0;
			AN_ENABLE       <= 1'b0;
			LP_FEC_REQ_STAT <= 1'b0;
			IRQ             <= 1'b0;
		end
		else
		begin
			TRAIN_EN        <= train_en_reg & treq & sw_en;
			FEC_EN          <= ctrl_reg[`KRAT_CTRL_FEC_EN];
			ADV_KR          <= ctrl_reg[`KRAT_CTRL_ADV_KR];
			AN_ENABLE       <= an_used;
			LP_FEC_REQ_STAT <= lp_fec;
			IRQ             <= |(irq_stat_reg & irq_mask_reg);
		end
	end

endmodule
`default_nettype wire

// File: verif/krat_lp_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far KR device: AN pins and training answer
module krat_lp_model (
	// Enable in, pins out
	input	wire logic	clk,
	input	wire logic	train_en,
	output	var logic	link_up,
	output	var logic	an_restart,
	output	var logic	fec_req,
	output	var logic	done
);
	int	dly = 0; // Training length, 0 never ends
	int	cnt = 0;
	initial {link_up, an_restart, fec_req, done} = 4'h0;
	// Pins set by the scenario
	task put(input logic [2:0] s);
		{link_up, an_restart, fec_req} <= s;
	endtask
	// Finish training after dly enabled cycles
	always @(posedge clk)
	begin
		cnt <= train_en ? cnt + 1 : 0;
		done <= train_en && dly != 0 && cnt >= dly;
	end
endmodule
`default_nettype wire

// File: verif/krat_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module krat_ctrl_properties (
	// Clock, reset, bus
	input	wire logic		CLK_SYS,
	input	wire logic		SYS_RST,
	input	wire logic [4:0]	AVS_ADDRESS,
	input	wire logic		AVS_WRITE,
	input	wire logic [3:0]	AVS_BYTEENABLE,
	input	wire logic [31:0]	AVS_WRITEDATA,
	// Pins
	input	wire logic		AN_RESTART,
	input	wire logic		AN_LINK_UP,
	input	wire logic		LP_FEC_REQ,
	input	wire logic		TRAIN_EN,
	input	wire logic		TRAIN_RESTART,
	input	wire logic		FEC_EN,
	input	wire logic		AN_ENABLE,
	input	wire logic		LP_FEC_REQ_STAT
);
	logic [1:0]	c_reg; // Control {b4, b0}
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	// Shadow of the enable bits
	always @(posedge CLK_SYS)
		if (SYS_RST)
			c_reg <= 2'b10;
		else if (AVS_WRITE && AVS_ADDRESS == 5'h00 && AVS_BYTEENABLE[0])
			c_reg <= {AVS_WRITEDATA[4], AVS_WRITEDATA[0]};
	sequence s_lu;
		AN_ENABLE && c_reg == 2'b11 && $rose(AN_LINK_UP);
	endsequence
	AST_LINKUP: assert property (s_lu |-> ##[2:9] TRAIN_RESTART)
		else $error("no restart on link-up");
	AST_RST_EN: assert property (TRAIN_RESTART |=> TRAIN_EN)
		else $error("restart without enable");
	AST_HOLD: assert property (AN_ENABLE && $rose(AN_RESTART) |-> ##[1:9] !TRAIN_EN)
		else $error("enable kept on AN restart");
	AST_NOREQ: assert property ((!c_reg[0])[*3] |-> !TRAIN_EN)
		else $error("training without request");
	AST_NOAN: assert property (!AN_ENABLE && c_reg == 2'b11 && $past(c_reg) == 2'b10
		|-> ##[1:3] TRAIN_RESTART)
		else $error("no start without AN");
	AST_FEC: assert property ($changed(FEC_EN) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2))
		else $error("FEC moved alone");
	AST_FECSTAT: assert property (LP_FEC_REQ[*8] |-> LP_FEC_REQ_STAT)
		else $error("FEC request not shown");
	AST_PULSE: assert property (TRAIN_RESTART |=> !TRAIN_RESTART)
		else $error("restart not a pulse");
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "krat_map.vh"
module tb;
	logic		clk = 0;
	logic		rst = 1;
	logic		rd = 0;
	logic		wr = 0;
	logic		anp = 0;
	logic		wq, irq, ten, trs, fec, adv, ane, fst, lu, ar, lf, td;
	logic [4:0]	a = 0;
	logic [3:0]	be = 4'h1;
	logic [31:0]	wd = 0, q, v;
	int		n_mismatch = 0;
	int		samples_checked = 0;
	// Rows: {AN present, control write, TE FEC KR AN, control readback}
	logic [23:0]	rows [6] = '{24'h0_10_0_10, 24'h0_11_8_11, 24'h0_1d_e_1d,
		24'h0_01_0_01, 24'h0_31_8_11, 24'h1_13_8_13};
	always #5 clk = ~clk;
	krat_lp_model lp (.clk(clk), .train_en(ten), .link_up(lu), .an_restart(ar),
		.fec_req(lf), .done(td));
	krat_ctrl #(.TRAIN_LIMIT_CYC(200)) dut (.CLK_SYS(clk), .SYS_RST(rst),
		.AVS_ADDRESS(a), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE(be),
		.AVS_WRITEDATA(wd), .AVS_READDATA(q), .AVS_WAITREQUEST(wq), .AN_PRESENT(anp),
		.AN_LINK_UP(lu), .AN_RESTART(ar), .LP_FEC_REQ(lf), .TRAIN_DONE(td),
		.TRAIN_EN(ten), .TRAIN_RESTART(trs), .FEC_EN(fec), .ADV_KR(adv),
		.AN_ENABLE(ane), .LP_FEC_REQ_STAT(fst), .IRQ(irq));
	task chk(input logic [31:0] s, e);
		samples_checked++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("BAD t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task wrr(input logic [4:0] ad, input logic [31:0] d);
		@(posedge clk);
		a <= ad;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		while (wq) @(posedge clk);
		wr <= 0;
	endtask
	task rdd(input logic [4:0] ad, output logic [31:0] d);
		@(posedge clk);
		a <= ad;
		rd <= 1;
		@(posedge clk);
		while (wq) @(posedge clk);
		d = q;
		rd <= 0;
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog against a hang
	initial
	begin
		#100000;
		n_mismatch++;
		end_sim;
	end
	// Reset, table rows, then hand tests
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 0;
		rdd(`KRAT_CTRL_OFS, v);
		chk(v, 32'h10);
		rdd(`KRAT_IRQ_MASK_OFS, v);
		chk(v | {25'h0, ten, trs, fec, adv, ane, fst, irq}, 32'h0);
		$display("reset test done");
		foreach (rows[i])
		begin
			anp <= rows[i][20];
			wrr(`KRAT_CTRL_OFS, {24'h0, rows[i][19:12]});
			repeat (3) @(posedge clk);
			chk({28'h0, ten, fec, adv, ane}, {28'h0, rows[i][11:8]});
			rdd(`KRAT_CTRL_OFS, v);
			chk(v, {24'h0, rows[i][7:0]});
			$display("row %0d done", i);
		end
		wrr(`KRAT_CTRL_OFS, 32'h10);
		wrr(`KRAT_CTRL_OFS, 32'h11);
		wrr(`KRAT_IRQ_MASK_OFS, 32'hf);
		repeat (8) @(posedge clk);
		chk({30'h0, ten, ane}, 32'h1);
		lp.dly = 20;
		lp.put(3'b101);
		repeat (50) @(posedge clk);
		chk({29'h0, fec, fst, irq}, 32'h3);
		rdd(`KRAT_STAT_OFS, v);
		chk(v & 32'h16, 32'h16);
		rdd(`KRAT_IRQ_STAT_OFS, v);
		chk(v, 32'hd);
		rdd(`KRAT_IRQ_STAT_OFS, v);
		repeat (2) @(posedge clk);
		chk(v | {31'h0, irq}, 32'h0);
		lp.put(3'b010);
		repeat (8) @(posedge clk);
		chk({31'h0, ten}, 32'h0);
		lp.dly = 0;
		lp.put(3'b100);
		repeat (260) @(posedge clk);
		rdd(`KRAT_STAT_OFS, v);
		chk(v & 32'h21, 32'h21);
		rdd(`KRAT_IRQ_STAT_OFS, v);
		chk(v, 32'h3);
		rdd(`KRAT_IRQ_STAT_OFS, v);
		chk(v, 32'h0);
		// Reset in mid-run, then a write with byte lane 0 off
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		chk({25'h0, ten, trs, fec, adv, ane, fst, irq}, 32'h0);
		be <= 4'h0;
		wrr(`KRAT_CTRL_OFS, 32'h01);
		be <= 4'h1;
		rdd(`KRAT_CTRL_OFS, v);
		chk(v, 32'h10);
		rdd(5'h10, v);
		chk(v, 32'h0);
		$display("hand tests done");
		end_sim;
	end
endmodule
bind krat_ctrl krat_ctrl_properties chk_i (.CLK_SYS, .SYS_RST, .AVS_ADDRESS, .AVS_WRITE,
	.AVS_BYTEENABLE, .AVS_WRITEDATA, .AN_RESTART, .AN_LINK_UP, .LP_FEC_REQ, .TRAIN_EN,
	.TRAIN_RESTART, .FEC_EN, .AN_ENABLE, .LP_FEC_REQ_STAT);
`default_nettype wire
